// *** inc/sad_pkg.sv ***
// Constants, commands and carriers for the stack ALU and shifter datapath
package sad_pkg;
  localparam int W = 16;
  localparam int AW = 8;
  // Register byte offsets
  localparam logic [7:0] OFF_TOP = 8'h00;
  localparam logic [7:0] OFF_SEC = 8'h04;
  localparam logic [7:0] OFF_CY = 8'h08;
  localparam logic [7:0] OFF_MD = 8'h0C;
  localparam logic [7:0] OFF_SR = 8'h10;
  localparam logic [7:0] OFF_ACCX = 8'h14;
  localparam logic [7:0] OFF_ACCL = 8'h18;
  localparam logic [7:0] OFF_ACCH = 8'h1C;
  localparam logic [7:0] OFF_EXEC = 8'h20;
  localparam logic [7:0] OFF_OPM = 8'h24;
  localparam logic [7:0] OFF_OPB = 8'h28;
  localparam logic [7:0] OFF_STAT = 8'h2C;
  // Reset values and fixed words
  localparam logic [15:0] RST_W = 16'h0000;
  localparam logic [15:0] ONES_W = 16'hFFFF;
  localparam logic [31:0] ZERO_32 = 32'h0000_0000;
  // Long ALU codes
  localparam logic [3:0] AL_AND = 4'h2, AL_NOR = 4'h3, AL_SSUB = 4'h4, AL_SSBC = 4'h5;
  localparam logic [3:0] AL_OR = 4'h6, AL_NAND = 4'h7, AL_ADD = 4'h8, AL_ADC = 4'h9;
  localparam logic [3:0] AL_XOR = 4'hA, AL_XNOR = 4'hB, AL_SUB = 4'hC, AL_SBC = 4'hD;
  // Short ALU codes
  localparam logic [2:0] AS_AND = 3'h1, AS_SSUB = 3'h2, AS_OR = 3'h3;
  localparam logic [2:0] AS_ADD = 3'h4, AS_XOR = 3'h5, AS_SUB = 3'h6;
  // Shift codes
  localparam logic [3:0] SH_NONE = 4'h0, SH_SEXT = 4'h1, SH_SHL = 4'h2, SH_ROL = 4'h3;
  localparam logic [3:0] SH_RSC = 4'h4, SH_RRC = 4'h5, SH_LSR = 4'h6, SH_ASR = 4'h7;
  localparam logic [3:0] SH_NSHL = 4'h8, SH_NROL = 4'h9, SH_DSHL = 4'hA, SH_DROL = 4'hB;
  localparam logic [3:0] SH_DRSC = 4'hC, SH_DRRC = 4'hD, SH_DLSR = 4'hE, SH_DASR = 4'hF;
  // Operation classes of an execute command
  typedef enum logic [4:0] {
    OP_ALU, OP_ALU_S, OP_DIV_STEP, OP_MUL_S, OP_MUL_U, OP_MUL_M, OP_MAC_S, OP_MAC_U,
    OP_MAC_M, OP_MSUB_S, OP_CLR_ACC, OP_SHR_ACC, OP_DSRA, OP_DSRL, OP_DSLL, OP_NORM,
    OP_ZERO, OP_MAC_STK, OP_MAC_BUS
  } sad_op_t;
  // Execute command word
  typedef struct packed {
    logic [14:0] rsvd;
    sad_op_t op;
    logic [3:0] amt;
    logic [3:0] shf;
    logic [3:0] alu;
  } sad_cmd_t;
endpackage

// *** hw/sad_datapath.sv ***
// Stack ALU, shifter, step math and multiply-accumulate datapath with APB registers
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/10ps
// Functional notes
// - Long 4-bit ALU code selects AND NOR swapped-sub OR NAND add XOR XNOR sub variants.
// - Short 3-bit ALU code selects AND swapped-sub OR add XOR subtract.
// - Code 0100 shifts ALU right, prior carry to bit 15, carry cleared.
// - Code 0101 rotates ALU right through carry; ALU bit 0 becomes carry.
// - Codes 1000/1001 load ALU into top, keep carry, shift second left, fill 0 or carry.
// - Codes 1010/1011 shift top:second left; carry gets ALU bit 15.
// - Code 1100 shifts top:second right, prior carry in, carry cleared.
// - Codes 0110/1110 logical right shift of top or top:second, carry cleared.
// - Codes 0111/1111 arithmetic right shift, bit 15 copied into carry.
// - Carry fed into bits is the value held before the instruction.
// - Signed, unsigned, mixed multiply and accumulate, multiply-subtract, clear accumulator.
// - Accumulator parts readable and loadable singly; accumulator can shift right.
// - Streamed accumulate from stack and memory, or peripheral bus and memory.
// - Double shifts right and left, normalize and test for zero.
module sad_datapath (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  logic [15:0] top_ff, sec_ff, md_ff, sr_ff, accx_ff, accl_ff, acch_ff, opm_ff, opb_ff;
  logic [15:0] nxt_top, nxt_sec, nxt_md, nxt_sr, nxt_accx, nxt_accl, nxt_acch;
  logic [15:0] nxt_opm, nxt_opb;
  logic cy_ff, nxt_cy;
  logic [4:0] nrm_ff, nxt_nrm;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
  logic hit, acc_ok, wr_ok, exec;
  logic [31:0] rd_mux;
  sad_pkg::sad_cmd_t cmd;
  logic [15:0] z;
  logic zc;
  logic [16:0] sum;
  logic [15:0] ts;
  logic [31:0] dsh;
  logic [4:0] nrm_n;
  logic [16:0] ma, mb;
  logic [33:0] prod;
  logic [47:0] acc, prod48;
  logic [16:0] drem, ddif;

  ////////////////////////////////////////////////////////////////////////
  // APB decode
  assign cmd = sad_pkg::sad_cmd_t'(pwdata);
  assign acc_ok = ce && psel && penable && pready_ff;
  assign wr_ok = acc_ok && pwrite && hit;
  assign exec = wr_ok && (paddr == sad_pkg::OFF_EXEC);
  assign acc = {accx_ff, acch_ff, accl_ff};

  // Read mux and hit
  always_comb begin
    hit = 1'b1;
    rd_mux = sad_pkg::ZERO_32;
    case (paddr)
      sad_pkg::OFF_TOP: rd_mux[15:0] = top_ff;
      sad_pkg::OFF_SEC: rd_mux[15:0] = sec_ff;
      sad_pkg::OFF_CY: rd_mux[0] = cy_ff;
      sad_pkg::OFF_MD: rd_mux[15:0] = md_ff;
      sad_pkg::OFF_SR: rd_mux[15:0] = sr_ff;
      sad_pkg::OFF_ACCX: rd_mux[15:0] = accx_ff;
      sad_pkg::OFF_ACCL: rd_mux[15:0] = accl_ff;
      sad_pkg::OFF_ACCH: rd_mux[15:0] = acch_ff;
      sad_pkg::OFF_EXEC: rd_mux = sad_pkg::ZERO_32;
      sad_pkg::OFF_OPM: rd_mux[15:0] = opm_ff;
      sad_pkg::OFF_OPB: rd_mux[15:0] = opb_ff;
      sad_pkg::OFF_STAT: rd_mux[6:0] = {nrm_ff, top_ff == sad_pkg::RST_W, cy_ff};
      default: hit = 1'b0;
    endcase
  end

  // Bus answer: one wait state, then pready
  always_comb begin
    nxt_pready = psel && penable && !pready_ff;
    nxt_pslverr = nxt_pready && !hit;
    nxt_prdata = nxt_pready && !pwrite ? rd_mux : sad_pkg::ZERO_32;
  end

  ////////////////////////////////////////////////////////////////////////
  // ALU, prior carry enters carry-in terms
  always_comb begin
    z = sad_pkg::RST_W;
    zc = cy_ff;
    sum = 17'h00000;
    if (cmd.op == sad_pkg::OP_ALU) begin
      case (cmd.alu)
        sad_pkg::AL_AND: z = top_ff & sec_ff;
        sad_pkg::AL_NOR: z = ~(top_ff | sec_ff);
        sad_pkg::AL_SSUB: sum = {1'b0, top_ff} + {1'b0, ~sec_ff} + 17'h00001;
        sad_pkg::AL_SSBC: sum = {1'b0, top_ff} + {1'b0, ~sec_ff} + {16'h0000, cy_ff};
        sad_pkg::AL_OR: z = top_ff | sec_ff;
        sad_pkg::AL_NAND: z = ~(top_ff & sec_ff);
        sad_pkg::AL_ADD: sum = {1'b0, sec_ff} + {1'b0, top_ff};
        sad_pkg::AL_ADC: sum = {1'b0, sec_ff} + {1'b0, top_ff} + {16'h0000, cy_ff};
        sad_pkg::AL_XOR: z = top_ff ^ sec_ff;
        sad_pkg::AL_XNOR: z = ~(top_ff ^ sec_ff);
        sad_pkg::AL_SUB: sum = {1'b0, sec_ff} + {1'b0, ~top_ff} + 17'h00001;
        sad_pkg::AL_SBC: sum = {1'b0, sec_ff} + {1'b0, ~top_ff} + {16'h0000, cy_ff};
        default: z = top_ff;
      endcase
    end else begin
      case (cmd.alu[2:0])
        sad_pkg::AS_AND: z = top_ff & sec_ff;
        sad_pkg::AS_SSUB: sum = {1'b0, top_ff} + {1'b0, ~sec_ff} + 17'h00001;
        sad_pkg::AS_OR: z = top_ff | sec_ff;
        sad_pkg::AS_ADD: sum = {1'b0, sec_ff} + {1'b0, top_ff};
        sad_pkg::AS_XOR: z = top_ff ^ sec_ff;
        sad_pkg::AS_SUB: sum = {1'b0, sec_ff} + {1'b0, ~top_ff} + 17'h00001;
        default: z = top_ff;
      endcase
    end
    // Only adder codes take the sum and its carry; logic codes keep the prior carry
    if (cmd.op == sad_pkg::OP_ALU ? cmd.alu inside {sad_pkg::AL_SSUB, sad_pkg::AL_SSBC,
        sad_pkg::AL_ADD, sad_pkg::AL_ADC, sad_pkg::AL_SUB, sad_pkg::AL_SBC} :
        cmd.alu[2:0] inside {sad_pkg::AS_SSUB, sad_pkg::AS_ADD, sad_pkg::AS_SUB}) begin
      z = sum[15:0];
      zc = sum[16];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Barrel shift, normalize count, multiplier and divide step
  always_comb begin
    ts = top_ff;
    dsh = {top_ff, sec_ff};
    nrm_n = 5'h00;
    for (int i = 0; i < 31; i++) begin
      if (dsh[i] != dsh[31]) nrm_n = 5'(30 - i);
    end
    case (cmd.op)
      sad_pkg::OP_DSRA: dsh = 32'($signed({top_ff, sec_ff}) >>> cmd.amt);
      sad_pkg::OP_DSRL: dsh = {top_ff, sec_ff} >> cmd.amt;
      sad_pkg::OP_DSLL: dsh = {top_ff, sec_ff} << cmd.amt;
      sad_pkg::OP_NORM: dsh = {top_ff, sec_ff} << nrm_n;
      default: dsh = {top_ff, sec_ff};
    endcase
    ma = {top_ff[15], top_ff};
    mb = {sec_ff[15], sec_ff};
    if (cmd.op == sad_pkg::OP_MAC_STK) mb = {opm_ff[15], opm_ff};
    if (cmd.op == sad_pkg::OP_MAC_BUS) begin
      ma = {opb_ff[15], opb_ff};
      mb = {opm_ff[15], opm_ff};
    end
    if (cmd.op == sad_pkg::OP_MUL_U || cmd.op == sad_pkg::OP_MAC_U) begin
      ma[16] = 1'b0;
      mb[16] = 1'b0;
    end
    if (cmd.op == sad_pkg::OP_MUL_M || cmd.op == sad_pkg::OP_MAC_M) mb[16] = 1'b0;
    prod = 34'($signed(ma) * $signed(mb));
    prod48 = {{14{prod[33]}}, prod};
    drem = {top_ff, sec_ff[15]};
    ddif = drem - {1'b0, md_ff};
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state of stack, carry and accumulator
  always_comb begin
    nxt_top = top_ff;
    nxt_sec = sec_ff;
    nxt_cy = cy_ff;
    nxt_nrm = nrm_ff;
    {nxt_accx, nxt_acch, nxt_accl} = acc;
    if (exec) begin
      case (cmd.op)
        sad_pkg::OP_ALU, sad_pkg::OP_ALU_S: begin
          nxt_top = z;
          nxt_cy = zc;
          case (cmd.shf)
            sad_pkg::SH_NONE: nxt_top = z;
            sad_pkg::SH_SEXT: nxt_top = {16{z[15]}};
            sad_pkg::SH_SHL: {nxt_cy, nxt_top} = {z, 1'b0};
            sad_pkg::SH_ROL: {nxt_cy, nxt_top} = {z, cy_ff};
            sad_pkg::SH_RSC: {nxt_top, nxt_cy} = {cy_ff, z[15:1], 1'b0};
            sad_pkg::SH_RRC: {nxt_top, nxt_cy} = {cy_ff, z};
            sad_pkg::SH_LSR: {nxt_top, nxt_cy} = {1'b0, z[15:1], 1'b0};
            sad_pkg::SH_ASR: {nxt_top, nxt_cy} = {z[15], z[15:1], z[15]};
            sad_pkg::SH_NSHL: {nxt_cy, nxt_sec} = {cy_ff, sec_ff[14:0], 1'b0};
            sad_pkg::SH_NROL: {nxt_cy, nxt_sec} = {cy_ff, sec_ff[14:0], cy_ff};
            sad_pkg::SH_DSHL: {nxt_cy, nxt_top, nxt_sec} = {z, sec_ff, 1'b0};
            sad_pkg::SH_DROL: {nxt_cy, nxt_top, nxt_sec} = {z, sec_ff, cy_ff};
            sad_pkg::SH_DRSC: {nxt_top, nxt_sec, nxt_cy} = {cy_ff, z, sec_ff[15:1], 1'b0};
            sad_pkg::SH_DRRC: {nxt_top, nxt_sec, nxt_cy} = {cy_ff, z, sec_ff};
            sad_pkg::SH_DLSR: {nxt_top, nxt_sec, nxt_cy} = {1'b0, z, sec_ff[15:1], 1'b0};
            sad_pkg::SH_DASR: {nxt_top, nxt_sec, nxt_cy} = {z[15], z, sec_ff[15:1], z[15]};
            default: nxt_top = z;
          endcase
        end
        sad_pkg::OP_DIV_STEP: begin
          // Restoring step: shift pair left, trial subtract of divisor
          nxt_cy = !ddif[16];
          nxt_top = ddif[16] ? drem[15:0] : ddif[15:0];
          nxt_sec = {sec_ff[14:0], !ddif[16]};
        end
        sad_pkg::OP_MUL_S, sad_pkg::OP_MUL_U, sad_pkg::OP_MUL_M:
          {nxt_accx, nxt_acch, nxt_accl} = prod48;
        sad_pkg::OP_MAC_S, sad_pkg::OP_MAC_U, sad_pkg::OP_MAC_M, sad_pkg::OP_MAC_STK,
        sad_pkg::OP_MAC_BUS:
          {nxt_accx, nxt_acch, nxt_accl} = acc + prod48;
        sad_pkg::OP_MSUB_S: {nxt_accx, nxt_acch, nxt_accl} = acc - prod48;
        sad_pkg::OP_CLR_ACC: {nxt_accx, nxt_acch, nxt_accl} = 48'h0000_0000_0000;
        sad_pkg::OP_SHR_ACC:
          {nxt_accx, nxt_acch, nxt_accl} = 48'($signed(acc) >>> cmd.amt);
        sad_pkg::OP_DSRA, sad_pkg::OP_DSRL, sad_pkg::OP_DSLL, sad_pkg::OP_NORM: begin
          {nxt_top, nxt_sec} = dsh;
          if (cmd.op == sad_pkg::OP_NORM) nxt_nrm = nrm_n;
        end
        sad_pkg::OP_ZERO:
          nxt_top = top_ff == sad_pkg::RST_W ? sad_pkg::ONES_W : sad_pkg::RST_W;
        default: nxt_top = top_ff;
      endcase
    end else if (wr_ok) begin
      if (paddr == sad_pkg::OFF_TOP) nxt_top = pwdata[15:0];
      if (paddr == sad_pkg::OFF_SEC) nxt_sec = pwdata[15:0];
      if (paddr == sad_pkg::OFF_CY) nxt_cy = pwdata[0];
      if (paddr == sad_pkg::OFF_ACCX) nxt_accx = pwdata[15:0];
      if (paddr == sad_pkg::OFF_ACCL) nxt_accl = pwdata[15:0];
      if (paddr == sad_pkg::OFF_ACCH) nxt_acch = pwdata[15:0];
    end
  end

  // Operand and step registers
  always_comb begin
    nxt_md = wr_ok && paddr == sad_pkg::OFF_MD ? pwdata[15:0] : md_ff;
    nxt_sr = wr_ok && paddr == sad_pkg::OFF_SR ? pwdata[15:0] : sr_ff;
    nxt_opm = wr_ok && paddr == sad_pkg::OFF_OPM ? pwdata[15:0] : opm_ff;
    nxt_opb = wr_ok && paddr == sad_pkg::OFF_OPB ? pwdata[15:0] : opb_ff;
  end

  ////////////////////////////////////////////////////////////////////////
  // State registers, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {top_ff, sec_ff, md_ff, sr_ff} <= {4{sad_pkg::RST_W}};
      {accx_ff, accl_ff, acch_ff, opm_ff, opb_ff} <= {5{sad_pkg::RST_W}};
      cy_ff <= 1'b0;
      nrm_ff <= 5'h00;
      prdata_ff <= sad_pkg::ZERO_32;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else if (ce) begin
      {top_ff, sec_ff, cy_ff} <= {nxt_top, nxt_sec, nxt_cy};
      {md_ff, sr_ff, opm_ff, opb_ff} <= {nxt_md, nxt_sr, nxt_opm, nxt_opb};
      {accx_ff, accl_ff, acch_ff} <= {nxt_accx, nxt_accl, nxt_acch};
      nrm_ff <= nxt_nrm;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  ////////////////////////////////////////////////////////////////////////
  // Checking helpers: last executed command and operands
  logic chk_v_ff;
  sad_pkg::sad_cmd_t chk_cmd_ff;
  logic [15:0] chk_z_ff, chk_top_ff, chk_sec_ff;
  logic chk_cy_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_v_ff <= 1'b0;
      chk_cmd_ff <= sad_pkg::sad_cmd_t'(sad_pkg::ZERO_32);
      {chk_z_ff, chk_top_ff, chk_sec_ff} <= {3{sad_pkg::RST_W}};
      chk_cy_ff <= 1'b0;
    end else if (ce) begin
      chk_v_ff <= exec;
      chk_cmd_ff <= cmd;
      {chk_z_ff, chk_top_ff, chk_sec_ff, chk_cy_ff} <= {z, top_ff, sec_ff, cy_ff};
    end
  end
  logic chk_alu;
  assign chk_alu = chk_v_ff && chk_cmd_ff.op == sad_pkg::OP_ALU;

  a_long_and: assert property (@(posedge pclk) disable iff (!presetn)
    chk_alu && chk_cmd_ff.alu == sad_pkg::AL_AND && chk_cmd_ff.shf == sad_pkg::SH_NONE
    |-> top_ff == (chk_top_ff & chk_sec_ff)) else $error("long and wrong");
  a_short_add: assert property (@(posedge pclk) disable iff (!presetn)
    chk_v_ff && chk_cmd_ff.op == sad_pkg::OP_ALU_S && chk_cmd_ff.alu[2:0] == sad_pkg::AS_ADD
    && chk_cmd_ff.shf == sad_pkg::SH_NONE |-> top_ff == 16'(chk_top_ff + chk_sec_ff))
    else $error("short add wrong");
  a_right_carry_out: assert property (@(posedge pclk) disable iff (!presetn)
    chk_alu && chk_cmd_ff.shf == sad_pkg::SH_RSC
    |-> top_ff == {chk_cy_ff, chk_z_ff[15:1]} && !cy_ff && sec_ff == chk_sec_ff)
    else $error("right shift out of carry wrong");
  a_rotate_right: assert property (@(posedge pclk) disable iff (!presetn)
    chk_alu && chk_cmd_ff.shf == sad_pkg::SH_RRC |-> cy_ff == chk_z_ff[0] && top_ff[15] ==
    chk_cy_ff) else $error("rotate right wrong");
  a_second_left: assert property (@(posedge pclk) disable iff (!presetn)
    chk_alu && chk_cmd_ff.shf == sad_pkg::SH_NROL |-> sec_ff == {chk_sec_ff[14:0], chk_cy_ff}
    && cy_ff == chk_cy_ff && top_ff == chk_z_ff) else $error("second left shift wrong");
  a_double_left: assert property (@(posedge pclk) disable iff (!presetn)
    chk_alu && chk_cmd_ff.shf == sad_pkg::SH_DSHL |-> {cy_ff, top_ff, sec_ff} ==
    {chk_z_ff, chk_sec_ff, 1'b0}) else $error("double left shift wrong");
  a_double_right: assert property (@(posedge pclk) disable iff (!presetn)
    chk_alu && chk_cmd_ff.shf == sad_pkg::SH_DRSC |-> !cy_ff && top_ff[15] == chk_cy_ff &&
    sec_ff[15] == chk_z_ff[0]) else $error("double right shift wrong");
  a_logic_right: assert property (@(posedge pclk) disable iff (!presetn)
    chk_alu && chk_cmd_ff.shf == sad_pkg::SH_DLSR |-> {top_ff, sec_ff} ==
    {1'b0, chk_z_ff, chk_sec_ff[15:1]} && !cy_ff) else $error("logical right wrong");
  a_arith_right: assert property (@(posedge pclk) disable iff (!presetn)
    chk_alu && chk_cmd_ff.shf == sad_pkg::SH_ASR |-> cy_ff == chk_z_ff[15] &&
    top_ff[15:14] == {2{chk_z_ff[15]}}) else $error("arithmetic right wrong");
  a_clear_acc: assert property (@(posedge pclk) disable iff (!presetn)
    exec && cmd.op == sad_pkg::OP_CLR_ACC |=> acc == 48'h0000_0000_0000)
    else $error("accumulator not cleared");
  a_bus_answer: assert property (@(posedge pclk) disable iff (!presetn)
    ce && psel && !penable ##1 ce && psel && penable |=> pready_ff) else $error("late pready");
  c_div_step: cover property (@(posedge pclk) disable iff (!presetn)
    exec && cmd.op == sad_pkg::OP_DIV_STEP ##[1:8] exec && cmd.op == sad_pkg::OP_DIV_STEP);
  c_mac: cover property (@(posedge pclk) disable iff (!presetn)
    exec && cmd.op == sad_pkg::OP_MAC_STK);
  c_norm: cover property (@(posedge pclk) disable iff (!presetn)
    exec && cmd.op == sad_pkg::OP_NORM && nrm_n != 5'h00);
endmodule

// *** bench/sad_tb.sv ***
// Self-checking bench for the stack ALU and shifter datapath
`timescale 1ns/10ps
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  int seed = 32'h591B;
  logic [47:0] acc_m = 48'h0;
  logic [31:0] rdat, r1, r2, e32;
  logic rerr;
  logic [15:0] t, n, md, hi, lo;
  logic [3:0] am;
  logic [4:0] nn;

  sad_datapath u_sad_datapath (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles = cycles + 1;
    if (cycles == 40000) begin
      fails = fails + 1;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // APB master: setup, access, hold until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the global cycle guard ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, {16'h0000, e});
    chk({31'h0, rerr}, 32'h0);
  endtask

  task automatic ex(input int op, input logic [3:0] al, input logic [3:0] sh, input logic [3:0] a);
    sad_pkg::sad_cmd_t c;
    c = '{rsvd: 15'h0000, op: sad_pkg::sad_op_t'(op), amt: a, shf: sh, alu: al};
    wr(sad_pkg::OFF_EXEC, c);
  endtask

  task automatic rd_acc();
    rd(sad_pkg::OFF_ACCX, acc_m[47:32]);
    rd(sad_pkg::OFF_ACCH, acc_m[31:16]);
    rd(sad_pkg::OFF_ACCL, acc_m[15:0]);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Expectation models
  function automatic logic [16:0] alu_f(logic [3:0] c, logic [15:0] a, logic [15:0] b, logic cy);
    case (c)
      4'h2: return {cy, a & b};
      4'h3: return {cy, ~(a | b)};
      4'h4: return {1'b0, a} + {1'b0, ~b} + 17'h00001;
      4'h5: return {1'b0, a} + {1'b0, ~b} + {16'h0000, cy};
      4'h6: return {cy, a | b};
      4'h7: return {cy, ~(a & b)};
      4'h8: return {1'b0, a} + {1'b0, b};
      4'h9: return {1'b0, a} + {1'b0, b} + {16'h0000, cy};
      4'hA: return {cy, a ^ b};
      4'hB: return {cy, ~(a ^ b)};
      4'hC: return {1'b0, b} + {1'b0, ~a} + 17'h00001;
      4'hD: return {1'b0, b} + {1'b0, ~a} + {16'h0000, cy};
      default: return {cy, a};
    endcase
  endfunction

  function automatic logic [32:0] shf_f(logic [3:0] s, logic [15:0] z, logic ca, logic cy,
                                        logic [15:0] b);
    case (s)
      4'h0: return {ca, z, b};
      4'h1: return {ca, {16{z[15]}}, b};
      4'h2: return {z[15], z[14:0], 1'b0, b};
      4'h3: return {z[15], z[14:0], cy, b};
      4'h4: return {1'b0, cy, z[15:1], b};
      4'h5: return {z[0], cy, z[15:1], b};
      4'h6: return {2'b00, z[15:1], b};
      4'h7: return {z[15], z[15], z[15:1], b};
      4'h8: return {cy, z, b[14:0], 1'b0};
      4'h9: return {cy, z, b[14:0], cy};
      4'hA: return {z[15], z[14:0], b[15], b[14:0], 1'b0};
      4'hB: return {z[15], z[14:0], b[15], b[14:0], cy};
      4'hC: return {1'b0, cy, z[15:1], z[0], b[15:1]};
      4'hD: return {b[0], cy, z[15:1], z[0], b[15:1]};
      4'hE: return {2'b00, z[15:1], z[0], b[15:1]};
      default: return {z[15], z[15], z[15:1], z[0], b[15:1]};
    endcase
  endfunction

  function automatic logic [47:0] mac_f(int op, logic [15:0] a, logic [15:0] b, logic [15:0] m,
                                        logic [15:0] g, logic [47:0] acc);
    logic signed [47:0] ps, pm, pt, pg;
    logic [47:0] pu;
    ps = $signed(a) * $signed(b);
    pt = $signed(a) * $signed(m);
    pg = $signed(g) * $signed(m);
    pm = $signed(a) * $signed({1'b0, b});
    pu = {32'h0, a} * {32'h0, b};
    case (op)
      3: return ps;
      4: return pu;
      5: return pm;
      6: return acc + ps;
      7: return acc + pu;
      8: return acc + pm;
      9: return acc - ps;
      17: return acc + pt;
      18: return acc + pg;
      default: return 48'h0;
    endcase
  endfunction

  // Load operands, run one ALU and shift command, compare all three results
  task automatic run_alu(input int op, input logic [3:0] al, input logic [3:0] sh,
                         input logic [15:0] a, input logic [15:0] b, input logic cy);
    logic [16:0] z;
    logic [32:0] e;
    z = alu_f((op == 1) ? {al[2:0], 1'b0} : al, a, b, cy);
    e = shf_f(sh, z[15:0], z[16], cy, b);
    wr(sad_pkg::OFF_TOP, {16'h0000, a});
    wr(sad_pkg::OFF_SEC, {16'h0000, b});
    wr(sad_pkg::OFF_CY, {31'h0, cy});
    ex(op, al, sh, 4'h0);
    rd(sad_pkg::OFF_TOP, e[31:16]);
    rd(sad_pkg::OFF_SEC, e[15:0]);
    rd(sad_pkg::OFF_CY, {15'h0000, e[32]});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a <= 40; a += 4) rd(8'(a), 16'h0000);
    $display("test reset done");
    for (int c = 2; c <= 13; c++) begin
      run_alu(0, 4'(c), sad_pkg::SH_NONE, 16'hFFFF, 16'h0001, 1'b1);
      repeat (3) begin
        r1 = $random(seed);
        run_alu(0, 4'(c), sad_pkg::SH_NONE, r1[15:0], r1[31:16], r1[7]);
      end
    end
    for (int c = 1; c <= 6; c++) begin
      r1 = $random(seed);
      run_alu(1, 4'(c), sad_pkg::SH_NONE, r1[15:0], r1[31:16], r1[3]);
    end
    $display("test alu done");
    for (int s = 0; s < 16; s++) begin
      run_alu(0, 4'h2, 4'(s), 16'h8001, 16'h8001, 1'b1);
      repeat (2) begin
        r1 = $random(seed);
        am = r1[10] ? sad_pkg::AL_ADC : sad_pkg::AL_XOR;
        run_alu(0, am, 4'(s), r1[15:0], r1[31:16], r1[9]);
      end
    end
    $display("test shift done");
    for (int i = 0; i < 5; i++) begin
      r1 = $random(seed);
      md = (i == 0) ? 16'hFFFF : (r1[15:0] | 16'h0001);
      hi = (i == 0) ? 16'hFFFE : (r1[31:16] % md);
      lo = r1[23:8];
      wr(sad_pkg::OFF_TOP, {16'h0000, hi});
      wr(sad_pkg::OFF_SEC, {16'h0000, lo});
      wr(sad_pkg::OFF_MD, {16'hA5A5, md});
      repeat (16) ex(2, 4'h0, 4'h0, 4'h0);
      rd(sad_pkg::OFF_SEC, 16'({hi, lo} / {16'h0000, md}));
      rd(sad_pkg::OFF_TOP, 16'({hi, lo} % {16'h0000, md}));
      rd(sad_pkg::OFF_MD, md);
    end
    wr(sad_pkg::OFF_SR, 32'hFFFF_8000);
    rd(sad_pkg::OFF_SR, 16'h8000);
    $display("test divide done");
    for (int i = 0; i < 20; i++) begin
      r1 = $random(seed);
      r2 = $random(seed);
      t = (i < 2) ? 16'h8000 : r1[15:0];
      n = (i < 2) ? 16'hFFFF : r1[31:16];
      wr(sad_pkg::OFF_TOP, {16'h0000, t});
      wr(sad_pkg::OFF_SEC, {16'h0000, n});
      wr(sad_pkg::OFF_OPM, r2);
      wr(sad_pkg::OFF_OPB, {r2[15:0], r2[31:16]});
      ex((i % 10 < 8) ? 3 + i % 10 : 9 + i % 10, 4'h0, 4'h0, 4'h0);
      acc_m = mac_f((i % 10 < 8) ? 3 + i % 10 : 9 + i % 10, t, n, r2[15:0], r2[31:16], acc_m);
      rd_acc();
    end
    repeat (3) begin
      r1 = $random(seed);
      r2 = $random(seed);
      acc_m = {r1[15:0], r2};
      wr(sad_pkg::OFF_ACCX, r1);
      wr(sad_pkg::OFF_ACCH, {16'h0000, r2[31:16]});
      wr(sad_pkg::OFF_ACCL, r2);
      rd_acc();
      am = r1[19:16];
      ex(11, 4'h0, 4'h0, am);
      acc_m = $signed(acc_m) >>> am;
      rd_acc();
    end
    $display("test mac done");
    for (int i = 0; i < 9; i++) begin
      r1 = $random(seed);
      am = (i < 3) ? 4'hF : r1[3:0];
      wr(sad_pkg::OFF_TOP, {16'h0000, r1[31:16]});
      wr(sad_pkg::OFF_SEC, {16'h0000, r1[15:0]});
      ex(12 + i % 3, 4'h0, 4'h0, am);
      case (i % 3)
        0: e32 = $signed(r1) >>> am;
        1: e32 = r1 >> am;
        default: e32 = r1 << am;
      endcase
      rd(sad_pkg::OFF_TOP, e32[31:16]);
      rd(sad_pkg::OFF_SEC, e32[15:0]);
    end
    // Normalize: shift left until the two top bits differ, count in status
    for (int i = 0; i < 6; i++) begin
      r1 = $random(seed);
      e32 = (i == 0) ? 32'h0000_0001 : (i == 1) ? 32'hC000_0000 : r1 >> r1[28:24];
      wr(sad_pkg::OFF_TOP, {16'h0000, e32[31:16]});
      wr(sad_pkg::OFF_SEC, {16'h0000, e32[15:0]});
      wr(sad_pkg::OFF_CY, {31'h0, r1[5]});
      ex(15, 4'h0, 4'h0, 4'h0);
      nn = 5'h00;
      while (e32[31] == e32[30] && e32 != 32'h0 && e32 != 32'hFFFF_FFFF) begin
        e32 = e32 << 1;
        nn++;
      end
      rd(sad_pkg::OFF_TOP, e32[31:16]);
      rd(sad_pkg::OFF_SEC, e32[15:0]);
      rd(sad_pkg::OFF_STAT, {9'h000, nn, e32[31:16] == 16'h0000, r1[5]});
    end
    for (int i = 0; i < 4; i++) begin
      r1 = $random(seed);
      t = (i % 2 == 0) ? 16'h0000 : (r1[15:0] | 16'h0100);
      wr(sad_pkg::OFF_TOP, {16'h0000, t});
      ex(16, 4'h0, 4'h0, 4'h0);
      rd(sad_pkg::OFF_TOP, (t == 16'h0000) ? sad_pkg::ONES_W : 16'h0000);
    end
    $display("test barrel done");
    // Clock enable low in the access phase must hold back the answer
    fork
      wr(sad_pkg::OFF_TOP, 32'h0000_1234);
      begin
        repeat (2) @(posedge pclk);
        ce <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({31'h0, pready}, 32'h0);
        @(posedge pclk);
        ce <= 1'b1;
      end
    join
    rd(sad_pkg::OFF_TOP, 16'h1234);
    $display("test enable done");
    apb(1'b0, 8'h30, 32'h0);
    chk(rdat, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    rd(sad_pkg::OFF_EXEC, 16'h0000);
    $display("test unmapped done");
    end_of_test();
  end
endmodule
